// file: shared/qpc_pkg.sv
// Package for the two-phase up/down counter block: register map, fields, modes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package qpc_pkg;

  localparam int unsigned NUM_CH   = 3;        // Channel 0 has no phase counting
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned STAT_W   = 8;
  localparam int unsigned ADDR_W   = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_START   = 8'h00;   // Run bits, one per channel
  localparam logic [7:0] OFF_IRQ_EN  = 8'h04;   // Mask, status layout
  localparam logic [7:0] OFF_MODE0   = 8'h10;   // Mode, channel n at +4n
  localparam logic [7:0] OFF_STAT0   = 8'h20;   // Status, channel n at +4n
  localparam logic [7:0] OFF_CNT0    = 8'h30;   // Counter, channel n at +4n
  localparam logic [7:0] CH_STRIDE   = 8'h04;

  // Status fields
  localparam int unsigned ST_DIR  = 7;
  localparam int unsigned ST_UNF  = 5;
  localparam int unsigned ST_OVF  = 4;
  localparam logic [7:0]  ST_W1C_MASK = 8'h3f;  // Flags cleared by writing one
  localparam logic [7:0]  ST_RESET    = 8'h80;  // Direction reads up after reset

  // Mode encodings
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_P1  = 3'h4;
  localparam logic [2:0] MODE_P2  = 3'h5;
  localparam logic [2:0] MODE_P3  = 3'h6;
  localparam logic [2:0] MODE_P4  = 3'h7;

  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Phase pair of one channel
  typedef struct packed {
    logic a;
    logic b;
  } qpc_phase_t;

  // One-cycle count request from a decoder
  typedef struct packed {
    logic step;
    logic up;
  } qpc_step_t;

endpackage : qpc_pkg

// file: testbench/qpc_enc_model.sv
// Encoder model: drives one channel's phase pair as a two-phase pattern.
// Assumes go_i is a one-cycle pulse, given only while busy_o is low.
`timescale 1ns/1ps
`default_nettype none
module qpc_enc_model #(
  parameter int GAP = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       up_i,
  input  wire logic [7:0] steps_i,
  output logic            busy_o,
  output logic            a_o,
  output logic            b_o
);
  logic [1:0] pos_reg;
  logic [7:0] left_reg;
  logic [7:0] tick_reg;
  logic       up_reg;

  // One pin edge per GAP cycles, so the pins never change together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg  <= 2'h0;
      left_reg <= 8'h00;
      tick_reg <= 8'h00;
      up_reg   <= 1'b1;
    end else if (go_i) begin
      left_reg <= steps_i;
      tick_reg <= 8'h00;
      up_reg   <= up_i;
    end else if (left_reg != 8'h00) begin
      if (tick_reg == 8'(GAP - 1)) begin
        tick_reg <= 8'h00;
        left_reg <= left_reg - 8'h01;
        pos_reg  <= up_reg ? pos_reg + 2'h1 : pos_reg - 2'h1;
      end else begin
        tick_reg <= tick_reg + 8'h01;
      end
    end
  end

  assign a_o    = pos_reg[1] ^ pos_reg[0];
  assign b_o    = pos_reg[1];
  assign busy_o = left_reg != 8'h00;
endmodule : qpc_enc_model
`default_nettype wire

// file: testbench/test_quadrature_phase_counter.sv
// Self-checking bench for the two-phase counter, one encoder model for each of channels one and two.
// Assumes the Wishbone slave answers within a few cycles and pins sync in 2 edges.
`timescale 1ns/1ps
`default_nettype none
module test_quadrature_phase_counter;
  import qpc_pkg::*;
  localparam logic [7:0] CNT1 = OFF_CNT0 + CH_STRIDE;
  localparam logic [7:0] CNT2 = OFF_CNT0 + 8'h08;
  localparam logic [7:0] ST1  = OFF_STAT0 + CH_STRIDE;
  localparam logic [7:0] ST2  = OFF_STAT0 + 8'h08;
  localparam logic [7:0] MD1  = OFF_MODE0 + CH_STRIDE;
  localparam logic [7:0] MD2  = OFF_MODE0 + 8'h08;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, up;
  logic [7:0]  adr_i, steps;
  logic [3:0]  sel_i, cmp_flag_set_i;
  logic [31:0] dat_i, dat_o;
  logic [1:0]  go, busy, pa, pb;
  int          mismatches, n_checks;

  qpc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ch1_phase_a_in_i(pa[0]), .ch1_phase_b_in_i(pb[0]), .ch2_phase_a_in_i(pa[1]),
    .ch2_phase_b_in_i(pb[1]), .cmp_flag_set_i(cmp_flag_set_i), .irq_o(irq_o));
  qpc_enc_model enc1_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go[0]), .up_i(up), .steps_i(steps),
    .busy_o(busy[0]), .a_o(pa[0]), .b_o(pb[0]));
  qpc_enc_model enc2_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go[1]), .up_i(up), .steps_i(steps),
    .busy_o(busy[1]), .a_o(pa[1]), .b_o(pb[1]));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    r = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask : irq_is

  // Run the encoders, then allow for synchroniser and edge-detect delay
  task automatic spin(input logic [1:0] chs, input logic dir, input logic [7:0] n);
    int k;
    go <= chs; up <= dir; steps <= n;
    @(posedge clk_i);
    go <= 2'h0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy !== 2'h0 && k < 2000);
    if (k >= 2000) chk(32'h0, 32'h1);
    repeat (4) @(posedge clk_i);
  endtask : spin

  task automatic t_reset();
    rd(CNT1, 32'h0);
    rd(ST1, 32'h80);
    rd(8'hfc, 32'h0);
    irq_is(1'b0);
  endtask : t_reset

  // Counts per eight pin edges: mode one 8, two 2, three 2, four 4
  task automatic t_modes();
    logic [2:0] md [4] = '{MODE_P1, MODE_P2, MODE_P3, MODE_P4};
    logic [7:0] dl [4] = '{8'h08, 8'h02, 8'h02, 8'h04};
    for (int i = 0; i < 4; i++) begin
      wr(OFF_START, 32'h0);
      wr(CNT1, 32'h100);
      wr(MD1, {29'h0, md[i]});
      wr(OFF_START, 32'h2);
      spin(2'h1, 1'b1, 8'h08);
      rd(CNT1, 32'h100 + dl[i]);
      rd(ST1, 32'h80);
      spin(2'h1, 1'b0, 8'h08);
      rd(CNT1, 32'h100);
      rd(ST1, 32'h00);
    end
  endtask : t_modes

  // Mode four stays in force after a refused and an invalid write
  task automatic t_refuse();
    wr(MD1, {29'h0, MODE_P1});
    wr(CNT1, 32'h0);
    spin(2'h1, 1'b1, 8'h04);
    rd(CNT1, 32'h2);
    wr(OFF_START, 32'h0);
    wr(MD1, 32'h1);
    wr(OFF_START, 32'h2);
    spin(2'h1, 1'b1, 8'h04);
    rd(CNT1, 32'h4);
  endtask : t_refuse

  task automatic t_runs();
    wr(OFF_START, 32'h0);
    wr(MD1, {29'h0, MODE_P1});
    wr(MD2, {29'h0, MODE_P1});
    wr(CNT1, 32'h0);
    wr(CNT2, 32'h0);
    wr(OFF_START, 32'h6);
    spin(2'h3, 1'b1, 8'h04);
    rd(CNT1, 32'h4);
    rd(CNT2, 32'h4);
    wr(OFF_START, 32'h4);
    spin(2'h3, 1'b1, 8'h04);
    rd(CNT1, 32'h4);
    rd(CNT2, 32'h8);
  endtask : t_runs

  task automatic t_wrap();
    wr(CNT2, 32'hfffe);
    spin(2'h2, 1'b1, 8'h04);
    rd(CNT2, 32'h2);
    rd(ST2, 32'h90);
    irq_is(1'b0);
    wr(OFF_IRQ_EN, 32'h10);
    irq_is(1'b1);
    spin(2'h2, 1'b0, 8'h04);
    rd(CNT2, 32'hfffe);
    rd(ST2, 32'h30);
    wr(ST2, 32'h10);
    rd(ST2, 32'h20);
    irq_is(1'b0);
    wr(OFF_IRQ_EN, 32'h20);
    irq_is(1'b1);
    wr(ST2, 32'h20);
    irq_is(1'b0);
  endtask : t_wrap

  task automatic t_cmp();
    logic [31:0] r;
    cmp_flag_set_i <= 4'ha;
    @(posedge clk_i);
    cmp_flag_set_i <= 4'h0;
    @(posedge clk_i);
    wb(1'b0, ST1, 32'h0, r);
    chk(r & 32'h0f, 32'h0a);
    wr(ST1, 32'h0f);
    wb(1'b0, ST1, 32'h0, r);
    chk(r & 32'h0f, 32'h00);
  endtask : t_cmp

  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'hf;
    dat_i = 32'h0; cmp_flag_set_i = 4'h0; go = 2'h0; up = 1'b1; steps = 8'h00;
    mismatches = 0; n_checks = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_modes();
    t_refuse();
    t_runs();
    t_wrap();
    t_cmp();
    tally_and_finish();
  end
endmodule : test_quadrature_phase_counter
`default_nettype wire

// file: verilog/qpc_decode.sv
// Phase decoder: turns one synchronised phase pair into count steps.
// Assumes phase inputs are already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module qpc_decode (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire qpc_pkg::qpc_phase_t ph_i,
  input  wire logic [2:0]        mode_i,
  output qpc_pkg::qpc_step_t     step_o
);
  import qpc_pkg::*;

  qpc_phase_t prev_reg;
  logic       a_rise, a_fall, b_rise, b_fall;

  // Previous sample for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= ph_i;
    end
  end

  assign a_rise = ph_i.a & ~prev_reg.a;
  assign a_fall = ~ph_i.a & prev_reg.a;
  assign b_rise = ph_i.b & ~prev_reg.b;
  assign b_fall = ~ph_i.b & prev_reg.b;

  // Count conditions per mode; simultaneous edges are ignored as noise, but mode three counts A fall with B rise and B fall with A rise
  always_comb begin
    step_o = '0;
    case (mode_i)
      MODE_P1: begin
        if ((a_rise | a_fall) ^ (b_rise | b_fall)) begin
          step_o.step = 1'b1;
          step_o.up   = (b_rise & ph_i.a) | (b_fall & ~ph_i.a) |
                        (a_rise & ~ph_i.b) | (a_fall & ph_i.b);
        end
      end
      MODE_P2: begin
        if (a_fall & ~(b_rise | b_fall)) begin
          step_o.step = 1'b1;
          step_o.up   = ph_i.b;
        end
      end
      // A fall up, B fall down
      MODE_P3: begin
        if (a_fall & ph_i.b & ~b_fall) begin
          step_o.step = 1'b1;
          step_o.up   = 1'b1;
        end else if (b_fall & ph_i.a & ~a_fall) begin
          step_o.step = 1'b1;
          step_o.up   = 1'b0;
        end
      end
      MODE_P4: begin
        if ((b_rise | b_fall) & ~(a_rise | a_fall)) begin
          step_o.step = 1'b1;
          step_o.up   = b_rise ? ph_i.a : ~ph_i.a;
        end
      end
      default: step_o = '0;
    endcase
  end

endmodule : qpc_decode
`default_nettype wire

// file: verilog/qpc_top.sv
// Two-phase up/down counter block with Wishbone register access.
// Assumes phase pins are asynchronous to clk_i (50 MHz) and a classic Wishbone master.
//
// Behaviour
// - Only channels one and two count phases; channel zero never does.
// - Mode 0 cancels phase counting and modes 4 to 7 select phase modes one to four.
// - Channels start and stop individually or together through one run register write.
// - A run bit of 1 lets the counter count and 0 halts it.
// - Status bit 7 shows the last count direction, 1 for up.
// - Status bit 5 sets on underflow in a phase mode.
// - Status bit 4 sets on overflow in a phase mode.
// - Status bits 3 to 0 hold the compare flags D, C, B and A.
// - Each channel has a 16-bit counter readable at any time.
// - Software may write the counter and counting resumes from that value.
// - Mode one counts every edge not paired with an edge on the other pin, up when A leads and down when B leads.
// - Modes two, three and four count on the edge subsets of A and B given for them.
`timescale 1ns/1ps
`default_nettype none
module qpc_top #(
  parameter int unsigned NCH = qpc_pkg::NUM_CH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [qpc_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  output logic                           ack_o,
  input  wire logic                      ch1_phase_a_in_i,
  input  wire logic                      ch1_phase_b_in_i,
  input  wire logic                      ch2_phase_a_in_i,
  input  wire logic                      ch2_phase_b_in_i,
  input  wire logic [3:0]                cmp_flag_set_i,
  output logic                           irq_o
);
  import qpc_pkg::*;

  logic [NCH-1:0]    run_reg;
  logic [STAT_W-1:0] irq_en_reg;
  logic [2:0]        mode_reg   [NCH];
  logic [5:0]        flag_reg   [NCH];
  logic [NCH-1:0]    dir_reg;
  logic [CNT_W-1:0]  cnt_reg    [NCH];
  logic [3:0]        ph_s1_reg, ph_s2_reg;
  qpc_phase_t        ph         [NCH];
  qpc_step_t         step       [NCH];
  logic              wb_req, wr_ok;
  logic [31:0]       rd_next;
  logic [STAT_W-1:0] st_view    [NCH];
  logic [STAT_W-1:0] pend_any;

  // Two flip-flops per phase pin; first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_s1_reg <= '0;
      ph_s2_reg <= '0;
    end else begin
      ph_s1_reg <= {ch2_phase_b_in_i, ch2_phase_a_in_i, ch1_phase_b_in_i, ch1_phase_a_in_i};
      ph_s2_reg <= ph_s1_reg;
    end
  end

  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign wr_ok  = wb_req & we_i & sel_i[0];

  // Per-channel counter, mode, flags and decoder
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam logic [7:0] MODE_A = OFF_MODE0 + 8'(g) * CH_STRIDE;
      localparam logic [7:0] STAT_A = OFF_STAT0 + 8'(g) * CH_STRIDE;
      localparam logic [7:0] CNT_A  = OFF_CNT0  + 8'(g) * CH_STRIDE;
      logic cnt_wr, stat_wr, wrap_up, wrap_dn, live;

      // channel zero sees no phase pins
      if (g == 0) begin : g_nophase
        assign ph[g] = '0;
      end else begin : g_phase
        assign ph[g] = '{a: ph_s2_reg[2*(g-1)], b: ph_s2_reg[2*(g-1)+1]};
      end

      qpc_decode u_dec (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ph_i   (ph[g]),
        .mode_i (mode_reg[g]),
        .step_o (step[g])
      );

      // counting only while run bit set
      assign live    = run_reg[g] & step[g].step;
      assign cnt_wr  = wb_req & we_i & (adr_i == CNT_A);
      assign stat_wr = wr_ok & (adr_i == STAT_A);
      assign wrap_up = live & step[g].up & (cnt_reg[g] == {CNT_W{1'b1}});
      assign wrap_dn = live & ~step[g].up & (cnt_reg[g] == '0);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mode_reg[g] <= MODE_OFF;
        end else if (wr_ok && adr_i == MODE_A && !run_reg[g] && g != 0) begin
          if (dat_i[2:0] == MODE_OFF || dat_i[2] == 1'b1) begin
            mode_reg[g] <= dat_i[2:0];
          end
        end
      end

      // Counter; a software write wins over a count in the same cycle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_reg[g] <= CNT_RESET;
        end else if (cnt_wr) begin
          // load from software, byte lanes honoured
          cnt_reg[g] <= {sel_i[1] ? dat_i[15:8] : cnt_reg[g][15:8],
                         sel_i[0] ? dat_i[7:0]  : cnt_reg[g][7:0]};
        end else if (live) begin
          cnt_reg[g] <= step[g].up ? cnt_reg[g] + 16'h0001 : cnt_reg[g] - 16'h0001;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dir_reg[g] <= ST_RESET[ST_DIR];
        end else if (live) begin
          dir_reg[g] <= step[g].up;
        end
      end

      // Sticky flags: set wins over write-one clear
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_reg[g] <= '0;
        end else begin
          flag_reg[g] <= (flag_reg[g] & ~(stat_wr ? dat_i[5:0] & ST_W1C_MASK[5:0] : 6'h00))
                       | {wrap_dn, 5'h00}
                       | {1'b0, wrap_up, 4'h0}
                       // compare flags D..A from capture logic
                       | {2'b00, cmp_flag_set_i};
        end
      end

      // Bit 6 reserved, reads zero
      assign st_view[g] = {dir_reg[g], 1'b0, flag_reg[g]};
    end
  endgenerate

  // one write starts or stops any channel set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= '0;
    end else if (wr_ok && adr_i == OFF_START) begin
      run_reg <= dat_i[NCH-1:0];
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= '0;
    end else if (wr_ok && adr_i == OFF_IRQ_EN) begin
      irq_en_reg <= dat_i[7:0] & ST_W1C_MASK;
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  always_comb begin
    rd_next = 32'h0000_0000;
    if (adr_i == OFF_START) begin
      rd_next = {{(32-NCH){1'b0}}, run_reg};
    end else if (adr_i == OFF_IRQ_EN) begin
      rd_next = {24'h000000, irq_en_reg};
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (adr_i == OFF_MODE0 + 8'(i) * CH_STRIDE) begin
          rd_next = {29'h0, mode_reg[i]};
        end else if (adr_i == OFF_STAT0 + 8'(i) * CH_STRIDE) begin
          rd_next = {24'h000000, st_view[i]};
        end else if (adr_i == OFF_CNT0 + 8'(i) * CH_STRIDE) begin
          rd_next = {16'h0000, cnt_reg[i]};
        end
      end
    end
  end

  // Single-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wb_req;
      dat_o <= (wb_req && !we_i) ? rd_next : 32'h0000_0000;
    end
  end

  // Interrupt level from any unmasked flag
  always_comb begin
    pend_any = '0;
    for (int i = 0; i < NCH; i++) begin
      pend_any = pend_any | (st_view[i] & ST_W1C_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(pend_any & irq_en_reg);
    end
  end

  // Assertions
  property run_gate_p;
    @(posedge clk_i) disable iff (rst_i)
      (run_reg[1] == 1'b0 && !(wb_req && we_i && adr_i == OFF_CNT0 + CH_STRIDE))
      |=> $stable(cnt_reg[1]);
  endproperty
  halt_holds_a: assert property (run_gate_p) else $error("Stopped channel changed count");

  mode_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_reg[1] |=> mode_reg[1] == $past(mode_reg[1])) else $error("Mode changed while running");

  mode_legal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg[1] == MODE_OFF || mode_reg[1][2]) else $error("Illegal mode held");

  ch0_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_reg[0] == MODE_OFF) else $error("Channel zero in phase mode");

  ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_reg[1] && step[1].step && step[1].up && cnt_reg[1] == 16'hffff
     && !(wb_req && we_i && adr_i == OFF_CNT0 + CH_STRIDE))
    |=> flag_reg[1][ST_OVF] && cnt_reg[1] == 16'h0000) else $error("Overflow not flagged");

  unf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_reg[2] && step[2].step && !step[2].up && cnt_reg[2] == 16'h0000
     && !(wb_req && we_i && adr_i == OFF_CNT0 + 8'h08))
    |=> flag_reg[2][ST_UNF] && cnt_reg[2] == 16'hffff) else $error("Underflow not flagged");

  dir_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_reg[1] && step[1].step) |=> st_view[1][ST_DIR] == $past(step[1].up)) else $error("Direction wrong");

  sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_reg[1][ST_OVF] && !(wr_ok && adr_i == OFF_STAT0 + CH_STRIDE)) |=> flag_reg[1][ST_OVF])
    else $error("Overflow flag dropped");

  sequence wr_cnt1_s;
    wb_req && we_i && adr_i == OFF_CNT0 + CH_STRIDE && sel_i[1:0] == 2'b11;
  endsequence
  cnt_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cnt1_s |=> cnt_reg[1] == $past(dat_i[15:0])) else $error("Counter load lost");

  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("Ack held two cycles");

  // Read data must not leak outside the acknowledged cycle
  rdata_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000) else $error("Read data outside ack");

  // Channel zero has no phase pins, so only software may move its count
  ch0_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_req && we_i && adr_i == OFF_CNT0) |=> $stable(cnt_reg[0])) else $error("Channel zero counted");

  // A fully masked block never raises the interrupt
  irq_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_en_reg == '0 |=> !irq_o) else $error("Masked interrupt raised");

endmodule : qpc_top
`default_nettype wire
